// file: hdl/tick_counter_slice.sv
// one tick counter with its expiry contact
`timescale 1ns/1ns
`include "timer_counter_contacts_consts.svh"

module tick_counter_slice (
    input  wire logic                                    clock,
    input  wire logic                                    arst_n,
    input  wire logic                                    enable,
    input  wire logic                                    tick,
    input  wire timer_counter_contacts_pkg::slice_ctrl_type ctrl,
    output logic [`COUNT_WIDTH-1:0]                      count,
    output logic                                         contact,
    output logic                                         contact_mode,
    output logic                                         expired
);
    import timer_counter_contacts_pkg::*;

    slice_state_type state;       // registered state
    slice_state_type next_state;  // next value

    // -------------------------------------------------
    // next state
    // -------------------------------------------------
    always_comb begin
        next_state = state;
        expired    = 1'b0;
        if (ctrl.start) begin
            // timed start: zero, arm, contact off
            next_state.mode     = mode_timing;
            next_state.count    = `COUNT_RESET;
            next_state.contact  = 1'b0;
            next_state.terminal = ctrl.terminal;
        end else if (ctrl.stop) begin
            // stop: zero, back to free run, contact kept
            next_state.mode  = mode_free;
            next_state.count = `COUNT_RESET;
        end else if (ctrl.clear) begin
            // software clear of the count
            next_state.count = `COUNT_RESET;
            if (state.mode != mode_free) begin
                next_state.mode    = mode_timing;
                next_state.contact = 1'b0;
            end
        end else begin
            case (state.mode)
                mode_free: begin
                    // free run, contact untouched
                    if (tick) begin
                        next_state.count = state.count + 1'b1;
                    end
                end
                mode_timing: begin
                    if (state.count >= state.terminal) begin
                        // halt and switch contact on
                        next_state.mode    = mode_halted;
                        next_state.contact = 1'b1;
                        expired            = 1'b1;
                    end else if (tick) begin
                        next_state.count = state.count + 1'b1;
                    end
                end
                mode_halted: begin
                    // hold count and contact
                    next_state.count = state.count;
                end
                default: begin
                    next_state.mode = mode_free;
                end
            endcase
        end
    end

    // -------------------------------------------------
    // state register
    // -------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else if (enable) begin
            state <= next_state;
        end
    end

    assign count        = state.count;
    assign contact      = state.contact;
    assign contact_mode = (state.mode != mode_free);

endmodule : tick_counter_slice

// file: hdl/timer_counter_contacts.sv
// eight tick counters with expiry contacts and register port
//
// Overview of operation
// - each counter free-runs 31 bits per tick
// - all counters start together at startup
// - timed start puts counter in contact mode
// - contact mode zeroes, counts, halts at terminal
// - stop zeroes counter, returns to free run
// - contact changes only on its timed instructions, at its halt and on a clear in contact mode
// - contact off when its counter zeroed by a timed start or by a clear in contact mode
// - contact on when counter halts
// - contact holds while counter free-runs
// - contacts readable as one word, reset zero
// - writing zero to counter clears it
`timescale 1ns/1ns
`include "timer_counter_contacts_consts.svh"

module timer_counter_contacts #(
    parameter int TICK_CYCLES = `TICK_CYCLES  // clocks per 10 ms tick
) (
    input  wire logic                                 clock,
    input  wire logic                                 arst_n,
    input  wire logic                                 enable,
    input  wire timer_counter_contacts_pkg::bus_req_type bus_req,
    output logic [`DATA_WIDTH-1:0]                    rdata,
    output logic [`NUM_COUNTERS-1:0]                  expiry_contact,
    output logic [15:0]                               packed_contact_word,
    output logic                                      irq
);
    import timer_counter_contacts_pkg::*;

    // -------------------------------------------------
    // constants
    // -------------------------------------------------
    localparam logic [`DIV_WIDTH-1:0] DIV_LAST =
        `DIV_WIDTH'(TICK_CYCLES - 1);       // last divider value
    localparam int NC = `NUM_COUNTERS;      // counter count

    // -------------------------------------------------
    // declarations
    // -------------------------------------------------
    top_state_type        state;            // registered state
    top_state_type        next_state;       // next value
    logic                 tick;             // one cycle per 10 ms
    slice_ctrl_type       ctrl [NC];        // per counter strobes
    logic [`COUNT_WIDTH-1:0] count [NC];    // counter values
    logic [NC-1:0]        contact;          // contact outputs
    logic [NC-1:0]        contact_mode;     // counter in contact mode
    logic [NC-1:0]        expired;          // halt events
    logic                 cmd_write;        // command word written
    logic [`CMD_INDEX_WIDTH-1:0] cmd_index; // addressed counter
    op_type               cmd_op;           // requested instruction
    logic                 count_sel;        // address hits a counter
    logic [`CMD_INDEX_WIDTH-1:0] count_idx; // counter under address
    logic [`DATA_WIDTH-1:0] read_value;     // read mux output

    // -------------------------------------------------
    // tick generator
    // -------------------------------------------------
    // divider and counters leave reset in the same
    // cycle, so all counters share one tick phase
    assign tick = (state.tick_div == DIV_LAST);

    // -------------------------------------------------
    // address decode
    // -------------------------------------------------
    // counters occupy one word each from the base
    assign count_sel = (bus_req.addr[7:5] == 3'h0) &&
                       (bus_req.addr[1:0] == 2'h0);
    assign count_idx = bus_req.addr[4:2];

    // command word fields
    assign cmd_write = bus_req.write &&
                       (bus_req.addr == `OFS_COMMAND);
    assign cmd_index = bus_req.wdata[`CMD_INDEX_LSB +: `CMD_INDEX_WIDTH];
    assign cmd_op    = op_type'(bus_req.wdata[`CMD_OP_LSB +: `CMD_OP_WIDTH]);

    // -------------------------------------------------
    // counter control strobes
    // -------------------------------------------------
    always_comb begin
        for (int k = 0; k < NC; k++) begin
            ctrl[k].start    = 1'b0;
            ctrl[k].stop     = 1'b0;
            ctrl[k].clear    = 1'b0;
            // duration in hundredths equals ticks
            ctrl[k].terminal = state.duration;
            if (cmd_write && (cmd_index == k[`CMD_INDEX_WIDTH-1:0])) begin
                case (cmd_op)
                    op_timer_set,
                    op_delay_on,
                    op_delay_off: begin
                        // a timed instruction, or a zero write in contact mode, moves a contact
                        ctrl[k].start = 1'b1;
                    end
                    op_timer_stop: begin
                        ctrl[k].stop = 1'b1;
                    end
                    default: begin
                        ctrl[k].stop = 1'b0;
                    end
                endcase
            end
            // zero written to a counter word clears it
            if (bus_req.write && count_sel &&
                (count_idx == k[`CMD_INDEX_WIDTH-1:0]) &&
                (bus_req.wdata == '0)) begin
                ctrl[k].clear = 1'b1;
            end
        end
    end

    // -------------------------------------------------
    // counter slices
    // -------------------------------------------------
    for (genvar g = 0; g < NC; g++) begin : g_slice
        tick_counter_slice u_slice (
            .clock        (clock),
            .arst_n       (arst_n),
            .enable       (enable),
            .tick         (tick),
            .ctrl         (ctrl[g]),
            .count        (count[g]),
            .contact      (contact[g]),
            .contact_mode (contact_mode[g]),
            .expired      (expired[g])
        );
    end

    // -------------------------------------------------
    // read mux
    // -------------------------------------------------
    always_comb begin
        read_value = '0;
        if (count_sel) begin
            // counter value, top bit reads zero
            read_value = {1'b0, count[count_idx]};
        end else begin
            case (bus_req.addr)
                `OFS_CONTACT_BITS: begin
                    read_value = {24'h000000, contact};
                end
                `OFS_CONTACT_WORD: begin
                    read_value = {16'h0000, packed_contact_word};
                end
                `OFS_DURATION: begin
                    read_value = {1'b0, state.duration};
                end
                `OFS_STATUS: begin
                    read_value = {24'h000000, state.status};
                end
                `OFS_MASK: begin
                    read_value = {24'h000000, state.mask};
                end
                `OFS_MODE: begin
                    read_value = {24'h000000, contact_mode};
                end
                default: begin
                    // unmapped and write-only read as zero
                    read_value = '0;
                end
            endcase
        end
    end

    // -------------------------------------------------
    // next state
    // -------------------------------------------------
    always_comb begin
        next_state = state;

        // divider wraps once per tick
        if (tick) begin
            next_state.tick_div = '0;
        end else begin
            next_state.tick_div = state.tick_div + 1'b1;
        end

        // duration and mask registers
        if (bus_req.write) begin
            case (bus_req.addr)
                `OFS_DURATION: begin
                    next_state.duration = bus_req.wdata[`COUNT_WIDTH-1:0];
                end
                `OFS_MASK: begin
                    next_state.mask = bus_req.wdata[NC-1:0];
                end
                default: begin
                    next_state.mask = state.mask;
                end
            endcase
        end

        // status: read clears, a new event wins
        if (bus_req.read && (bus_req.addr == `OFS_STATUS)) begin
            next_state.status = expired;
        end else begin
            next_state.status = state.status | expired;
        end

        // read data valid only in the cycle after a read
        if (bus_req.read) begin
            next_state.rdata = read_value;
        end else begin
            next_state.rdata = '0;
        end
    end

    // -------------------------------------------------
    // state register
    // -------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state.tick_div <= '0;
            state.duration <= `DURATION_RESET;
            state.status   <= `STATUS_RESET;
            state.mask     <= `MASK_RESET;
            state.rdata    <= '0;
        end else if (enable) begin
            state <= next_state;
        end
    end

    // -------------------------------------------------
    // outputs
    // -------------------------------------------------
    assign rdata               = state.rdata;
    assign expiry_contact      = contact;
    assign packed_contact_word = {8'h00, contact};
    assign irq                 = |(state.status & state.mask);

endmodule : timer_counter_contacts

// file: hdl/timer_counter_contacts_consts.svh
// constants for the timer counter and contact block
`ifndef TIMER_COUNTER_CONTACTS_CONSTS_SVH
`define TIMER_COUNTER_CONTACTS_CONSTS_SVH

// timing
`define CLOCK_FREQ_KHZ    125000
`define TICK_PERIOD_MS    10
`define TICK_CYCLES       (`CLOCK_FREQ_KHZ * `TICK_PERIOD_MS)
`define DIV_WIDTH         24

// sizes
`define COUNT_WIDTH       31
`define NUM_COUNTERS      8
`define ADDR_WIDTH        8
`define DATA_WIDTH        32

// byte offsets
`define OFS_COUNT_BASE    8'h00
`define OFS_CONTACT_BITS  8'h20
`define OFS_CONTACT_WORD  8'h24
`define OFS_COMMAND       8'h28
`define OFS_DURATION      8'h2C
`define OFS_STATUS        8'h30
`define OFS_MASK          8'h34
`define OFS_MODE          8'h38

// command word fields
`define CMD_INDEX_LSB     0
`define CMD_INDEX_WIDTH   3
`define CMD_OP_LSB        4
`define CMD_OP_WIDTH      2

// reset values
`define CONTACT_RESET     8'h00
`define MASK_RESET        8'h00
`define STATUS_RESET      8'h00
`define DURATION_RESET    31'h00000000
`define COUNT_RESET       31'h00000000

`endif

// file: hdl/timer_counter_contacts_pkg.sv
// types shared by the timer counter and contact block
`include "timer_counter_contacts_consts.svh"

package timer_counter_contacts_pkg;

    // instruction codes carried in the command word
    typedef enum logic [1:0] {
        op_timer_set  = 2'h0,
        op_delay_on   = 2'h1,
        op_delay_off  = 2'h2,
        op_timer_stop = 2'h3
    } op_type;

    // counter mode, gray along free -> timing -> halted
    typedef enum logic [1:0] {
        mode_free   = 2'h0,
        mode_timing = 2'h1,
        mode_halted = 2'h3
    } mode_type;

    // register port request
    typedef struct packed {
        logic [`ADDR_WIDTH-1:0] addr;
        logic [`DATA_WIDTH-1:0] wdata;
        logic                   write;
        logic                   read;
    } bus_req_type;

    // per counter control strobes
    typedef struct packed {
        logic                    start;
        logic                    stop;
        logic                    clear;
        logic [`COUNT_WIDTH-1:0] terminal;
    } slice_ctrl_type;

    // per counter state
    typedef struct packed {
        mode_type                mode;
        logic                    contact;
        logic [`COUNT_WIDTH-1:0] count;
        logic [`COUNT_WIDTH-1:0] terminal;
    } slice_state_type;

    // top level state
    typedef struct packed {
        logic [`DIV_WIDTH-1:0]    tick_div;
        logic [`COUNT_WIDTH-1:0]  duration;
        logic [`NUM_COUNTERS-1:0] status;
        logic [`NUM_COUNTERS-1:0] mask;
        logic [`DATA_WIDTH-1:0]   rdata;
    } top_state_type;

endpackage : timer_counter_contacts_pkg

// file: tb/program_model.sv
// user program model driving the register port
`timescale 1ns/1ns
`include "timer_counter_contacts_consts.svh"

module program_model (
    input  wire logic                               clock,
    output timer_counter_contacts_pkg::bus_req_type bus_req
);
    import timer_counter_contacts_pkg::*;

    initial bus_req = '0;

    // one cycle write, released lines flip so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        bus_req <= '{addr: ~a, wdata: ~d, write: 1'b0, read: 1'b0};
    endtask : wr

    // one cycle read, data is picked up by the bench monitor
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 32'h5A5AA5A5, write: 1'b0, read: 1'b1};
        @(posedge clock);
        bus_req <= '{addr: ~a, wdata: 32'hA5A55A5A, write: 1'b0, read: 1'b0};
    endtask : rd

    // timed instruction: duration in hundredths of a second, then command
    task automatic timed(input int k, input logic [1:0] op, input int hundredths);
        wr(`OFS_DURATION, 32'(hundredths));
        wr(`OFS_COMMAND, {26'h0, op, 1'b0, 3'(k)});
    endtask : timed
endmodule : program_model

// file: tb/timer_counter_contacts_asserts.sv
// port assertions for the timer counter block
`timescale 1ns/1ns
`include "timer_counter_contacts_consts.svh"

module timer_counter_contacts_checker #(
    parameter int TICK_CYCLES = 4  // clocks per tick
) (
    input wire logic                                  clock,
    input wire logic                                  arst_n,
    input wire logic                                  enable,
    input wire timer_counter_contacts_pkg::bus_req_type bus_req,
    input wire logic [`DATA_WIDTH-1:0]                rdata,
    input wire logic [`NUM_COUNTERS-1:0]              expiry_contact,
    input wire logic [15:0]                           packed_contact_word,
    input wire logic                                  irq
);
    import timer_counter_contacts_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    logic cmd_go;  // command write taken
    logic rd_go;   // read taken
    assign cmd_go = enable && bus_req.write && bus_req.addr == `OFS_COMMAND;
    assign rd_go  = enable && bus_req.read;

    sequence s_status_read;
        rd_go && bus_req.addr == `OFS_STATUS;
    endsequence
    sequence s_quiet;
        expiry_contact == $past(expiry_contact);
    endsequence

    property p_word;
        packed_contact_word == {8'h00, expiry_contact};
    endproperty
    property p_word_read;
        rd_go && bus_req.addr == `OFS_CONTACT_WORD |=> rdata == {16'h0, $past(packed_contact_word)};
    endproperty
    property p_bits_read;
        rd_go && bus_req.addr == `OFS_CONTACT_BITS |=> rdata == {24'h0, $past(expiry_contact)};
    endproperty
    property p_no_fall;
        !(enable && bus_req.write) |=> ($past(expiry_contact) & ~expiry_contact) == 8'h00;
    endproperty
    property p_start_off;
        cmd_go && bus_req.wdata[5:4] != 2'h3 |=> !expiry_contact[$past(bus_req.wdata[2:0])];
    endproperty
    property p_stop_hold;
        cmd_go && bus_req.wdata[5:4] == 2'h3
            |=> expiry_contact[$past(bus_req.wdata[2:0])]
                == $past(expiry_contact[bus_req.wdata[2:0]]);
    endproperty
    property p_irq_rise;
        $rose(irq) |-> (expiry_contact & ~$past(expiry_contact)) != 8'h00
            || $past(enable && bus_req.write && bus_req.addr == `OFS_MASK);
    endproperty
    property p_status_clear;
        s_status_read ##1 s_quiet |-> !irq;
    endproperty

    a_word:         assert property (p_word) else $error("word differs from contacts");
    a_word_read:    assert property (p_word_read) else $error("word read wrong");
    a_bits_read:    assert property (p_bits_read) else $error("bits read wrong");
    a_no_fall:      assert property (p_no_fall) else $error("contact fell unasked");
    a_start_off:    assert property (p_start_off) else $error("start left contact on");
    a_stop_hold:    assert property (p_stop_hold) else $error("stop changed contact");
    a_irq_rise:     assert property (p_irq_rise) else $error("irq rose without cause");
    a_status_clear: assert property (p_status_clear) else $error("irq after status read");
endmodule : timer_counter_contacts_checker

bind timer_counter_contacts timer_counter_contacts_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clock(clock), .arst_n(arst_n), .enable(enable), .bus_req(bus_req), .rdata(rdata),
    .expiry_contact(expiry_contact), .packed_contact_word(packed_contact_word), .irq(irq));

// file: tb/timer_counter_contacts_bench.sv
// self-checking bench for the timer counter block
`timescale 1ns/1ns
`include "timer_counter_contacts_consts.svh"

module timer_counter_contacts_bench;
    import timer_counter_contacts_pkg::*;
    localparam int TC = 4;          // short tick for simulation
    logic          clock  = 1'b0;   // 125 MHz
    logic          arst_n = 1'b0;   // reset, active low
    logic          enable = 1'b0;   // clock enable
    bus_req_type   bus_req;         // driven by program model
    logic [31:0]   rdata;           // read data
    logic [7:0]    expiry_contact;  // contacts
    logic [15:0]   packed_contact_word;
    logic          irq;
    int            num_errors = 0;
    int            checks = 0;
    int            seed = 32'h367AF8BB;
    int            cyc = 0;         // edges since release
    int            k, d, m, i;
    logic [31:0]   lo, hi;          // expected read window
    logic [31:0]   exp_lo[$];       // expected notes
    logic [31:0]   exp_hi[$];
    logic          rd_seen = 1'b0;  // read taken last edge
    logic [7:0]    exp_c = 8'h00;   // expected contacts
    logic [7:0]    exp_m = 8'h00;   // expected contact mode bits

    always #4 clock = ~clock;
    always @(posedge clock) cyc <= arst_n ? cyc + 1 : 0;

    program_model u_prog (.clock(clock), .bus_req(bus_req));
    timer_counter_contacts #(.TICK_CYCLES(TC)) u_dut (
        .clock(clock), .arst_n(arst_n), .enable(enable), .bus_req(bus_req), .rdata(rdata),
        .expiry_contact(expiry_contact), .packed_contact_word(packed_contact_word), .irq(irq));

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // monitor takes the oldest note when read data stands
    always @(posedge clock) begin
        if (rd_seen) begin
            lo = exp_lo.pop_front();
            hi = exp_hi.pop_front();
            check((rdata >= lo && rdata <= hi) ? lo : rdata, lo);
        end
        rd_seen <= bus_req.read;
    end

    // note expected window, then read
    task automatic rd(input logic [7:0] a, input logic [31:0] l, input logic [31:0] h);
        exp_lo.push_back(l);
        exp_hi.push_back(h);
        u_prog.rd(a);
    endtask : rd

    task automatic complete_run;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // bounded wait for contact k, n edges counted
    task automatic wait_contact(input int idx, output int n);
        n = 0;
        while (expiry_contact[idx] !== 1'b1 && n < 300) begin
            @(posedge clock);
            n++;
        end
        if (n >= 300) begin
            num_errors++;
            complete_run();
        end
    endtask : wait_contact

    initial begin
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        enable <= 1'b1;
        // --------------------------------
        // reset values and free run start
        // --------------------------------
        rd(`OFS_CONTACT_WORD, 0, 0);
        rd(`OFS_CONTACT_BITS, 0, 0);
        rd(`OFS_STATUS, 0, 0);
        rd(8'hFC, 0, 0);
        for (i = 0; i < 8; i++) begin
            rd(8'(i * 4), (cyc > TC) ? cyc / TC - 1 : 0, cyc / TC + 2);
        end
        u_prog.wr(`OFS_CONTACT_WORD, 32'hFF);
        u_prog.wr(8'h04, 32'h5);
        rd(`OFS_CONTACT_WORD, 0, 0);
        u_prog.wr(`OFS_MASK, 32'hFF);
        rd(`OFS_MASK, 32'hFF, 32'hFF);
        $display("reset and refusals done");
        // --------------------------------
        // timed instructions, the three timed opcodes
        // --------------------------------
        for (i = 0; i < 6; i++) begin
            k = $unsigned($random(seed)) % 8;
            d = 2 + $unsigned($random(seed)) % 6;
            u_prog.timed(k, 2'(i % 3), d);
            exp_c[k] = 1'b0;
            exp_m[k] = 1'b1;
            rd(`OFS_MODE, exp_m, exp_m);
            rd(`OFS_CONTACT_WORD, exp_c, exp_c);
            wait_contact(k, m);
            check((m >= (d - 1) * TC && m <= d * TC + 2) ? 1 : 0, 1);
            check(irq, 1'b1);
            exp_c[k] = 1'b1;
            rd(8'(k * 4), d, d);
            rd(`OFS_STATUS, 32'(1) << k, 32'(1) << k);
            rd(`OFS_CONTACT_BITS, exp_c, exp_c);
        end
        $display("timed instructions done");
        // --------------------------------
        // stop and clear by writing zero
        // --------------------------------
        u_prog.wr(`OFS_COMMAND, {26'h0, 2'h3, 1'b0, 3'(k)});
        rd(`OFS_CONTACT_WORD, exp_c, exp_c);
        exp_m[k] = 1'b0;
        rd(`OFS_MODE, exp_m, exp_m);
        repeat (40) @(posedge clock);
        rd(8'(k * 4), 9, 11);
        u_prog.wr(8'(k * 4), 32'h0);
        rd(8'(k * 4), 0, 1);
        rd(`OFS_CONTACT_WORD, exp_c, exp_c);
        repeat (3) @(posedge clock);
        $display("stop and clear done");
        complete_run();
    end
endmodule : timer_counter_contacts_bench
